// File: sensor_port_pkg.sv
// constants, state codes and crc helpers for the sensor register port
package sensor_port_pkg;
  // 7-bit base address; even selects plain framing, odd adds crc
  localparam logic [6:0] SLAVE_BASE = 7'h6c;
  localparam logic [7:0] ADDR_CMD = 8'h22;
  localparam logic [7:0] ADDR_TEMP = 8'h2e;
  localparam logic [7:0] ADDR_PRESS = 8'h30;
  localparam logic [7:0] ADDR_SYNC = 8'h32;
  localparam logic [7:0] ADDR_STAT = 8'h36;
  localparam logic [15:0] CMD_SLEEP = 16'h6c32;
  localparam logic [15:0] CMD_RESET = 16'hb169;
  localparam logic [3:0] CRC4_POLY = 4'h3;
  localparam logic [3:0] CRC4_INIT = 4'hf;
  localparam logic [7:0] CRC8_POLY = 8'hd5;
  localparam logic [7:0] CRC8_INIT = 8'hff;
  localparam logic [7:0] TX_FILL = 8'hff;
  localparam int B_IDLE = 0;
  localparam int B_S_UP = 3;
  localparam int B_T_UP = 4;
  localparam int B_BS = 7;
  localparam int B_BC = 8;
  localparam int B_SAT = 10;
  localparam int B_CRC = 11;
  localparam int B_S_MISS = 14;
  localparam int B_T_MISS = 15;
  localparam logic [15:0] EVENT_MASK = 16'hc998;
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] CRC_LEN_MAX = 4'h3;
  localparam int NIB = 4;
  localparam int BYTE = 8;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RX = 4'b0010,
    ST_TX = 4'b0100,
    ST_IGN = 4'b1000
  } link_st_t;

  // msb-first, as the bits travel on the wire
  function automatic logic [7:0] crc8_byte(input logic [7:0] c_in, input logic [7:0] d);
    logic [7:0] c;
    logic fb;
    c = c_in;
    for (int i = 7; i >= 0; i--) begin
      fb = c[7] ^ d[i];
      c = {c[6:0], 1'b0} ^ (fb ? CRC8_POLY : 8'h00);
    end
    return c;
  endfunction : crc8_byte

  // first n bits of d, msb first
  function automatic logic [3:0] crc4_bits(input logic [3:0] c_in, input logic [7:0] d,
                                          input int n);
    logic [3:0] c;
    logic fb;
    c = c_in;
    for (int i = 0; i < 8; i++) begin
      if (i < n) begin
        fb = c[3] ^ d[7-i];
        c = {c[2:0], 1'b0} ^ (fb ? CRC4_POLY : 4'h0);
      end
    end
    return c;
  endfunction : crc4_bits
endpackage : sensor_port_pkg

// File: link_wake.sv
// scl-clocked wake catcher with a level echo crossing back to the core clock
`timescale 1ns/10ps
module link_wake import sensor_port_pkg::*; (
  input logic scl,
  input logic clk,
  input logic rst_b,
  input logic sleep_req,
  output logic wake_pulse
);
  logic slp_s1_r, slp_s2_r, seen_r;
  logic w_s1_r, w_s2_r, w_d_r, w_d_nxt, wake_r, wake_nxt;

  // no reset here: scl may stand still through reset, and a pure
  // shift of the sleep level flushes itself within three scl rises
  always_ff @(posedge scl) begin
    slp_s1_r <= sleep_req;
    slp_s2_r <= slp_s1_r;
    seen_r <= slp_s2_r;
  end

  // only a rise of the echo wakes, so a stale high level cannot re-wake
  always_comb begin
    w_d_nxt = rst_b ? w_s2_r : 1'b0;
    wake_nxt = rst_b & w_s2_r & ~w_d_r;
  end

  always_ff @(posedge clk) begin
    w_s1_r <= seen_r;
    w_s2_r <= w_s1_r;
    w_d_r <= w_d_nxt;
    wake_r <= wake_nxt;
  end

  assign wake_pulse = wake_r;
endmodule : link_wake

// File: sensor_port.sv
// i2c register port of the pressure sensor, with optional crc framing
`timescale 1ns/10ps
module sensor_port import sensor_port_pkg::*; (
  input logic clk,
  input logic rst_b,
  input logic scl,
  input logic sda_i,
  output logic sda_o,
  output logic sda_oe_b,
  input logic [15:0] temp_value,
  input logic temp_load,
  input logic [15:0] press_value,
  input logic press_load,
  input logic idle_in,
  input logic dsp_sat_in,
  input logic bs_fail_ev,
  input logic bc_fail_ev,
  output logic sleep_mode,
  output logic reload_req,
  output logic [15:0] temp_result
);
  logic scl_s1_r, scl_s2_r, scl_d_r, sda_s1_r, sda_s2_r, sda_d_r;
  logic scl_rise, scl_fall, start_det, stop_det, wake_pulse;
  link_st_t st_r, st_nxt;
  logic [3:0] bit_cnt_r, bit_cnt_nxt, byte_idx_r, byte_idx_nxt, len_r, len_nxt;
  logic [3:0] crc4_r, crc4_nxt;
  logic [7:0] sh_r, sh_nxt, crc8_r, crc8_nxt, tx_sh_r, tx_sh_nxt, rx_byte;
  logic [7:0] base_r, base_nxt, ptr_r, ptr_nxt, rd_addr_r, rd_addr_nxt;
  logic [7:0] commit_base_r, commit_base_nxt;
  logic [15:0] tx_word_r, tx_word_nxt;
  logic [31:0] hold_r, hold_nxt;
  logic [4:0] data_cnt_r, data_cnt_nxt;
  logic [1:0] commit_left_r, commit_left_nxt;
  logic crc_mode_r, crc_mode_nxt, rd_mode_r, rd_mode_nxt, hdr_ok_r, hdr_ok_nxt;
  logic hi_sel_r, hi_sel_nxt, ack_drv_r, ack_drv_nxt, oe_b_r, oe_b_nxt;
  logic frame_open_r, frame_open_nxt, rd_fetch_r, rd_fetch_nxt, crc_err_r, crc_err_nxt;
  logic crc8_bad, data_byte, wr_en;
  logic [15:0] status_r, status_nxt, temp_r, temp_nxt, press_r, press_nxt;
  logic [15:0] set_v, clr_v, status_word, sync_word;
  logic [1:0] sync_up_r, sync_up_nxt;
  logic sleep_r, sleep_nxt, reload_r, reload_nxt, sda_o_r;

  link_wake u_wake (
    .scl(scl),
    .clk(clk),
    .rst_b(rst_b),
    .sleep_req(sleep_r),
    .wake_pulse(wake_pulse)
  );

  // oversampled bus: 25 core clocks per scl period at the bench rate
  always_ff @(posedge clk) begin
    scl_s1_r <= rst_b ? scl : 1'b1;
    scl_s2_r <= rst_b ? scl_s1_r : 1'b1;
    scl_d_r <= rst_b ? scl_s2_r : 1'b1;
    sda_s1_r <= rst_b ? sda_i : 1'b1;
    sda_s2_r <= rst_b ? sda_s1_r : 1'b1;
    sda_d_r <= rst_b ? sda_s2_r : 1'b1;
  end

  assign scl_rise = scl_s2_r & ~scl_d_r;
  assign scl_fall = ~scl_s2_r & scl_d_r;
  assign start_det = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
  assign stop_det = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;
  assign wr_en = commit_left_r != 2'd0;

  always_comb begin
    status_word = status_r;
    status_word[B_IDLE] = idle_in;
    status_word[B_SAT] = dsp_sat_in;
    sync_word = status_word;
    sync_word[B_T_UP] = sync_up_r[1];
    sync_word[B_S_UP] = sync_up_r[0];
  end

  function automatic logic [15:0] read_map(input logic [7:0] a);
    case (a)
      ADDR_TEMP: read_map = temp_r;
      ADDR_PRESS: read_map = press_r;
      ADDR_SYNC: read_map = sync_word;
      ADDR_STAT: read_map = status_word;
      default: read_map = 16'h0000;
    endcase
  endfunction : read_map

  function automatic logic [4:0] cnt_inc(input logic [4:0] c);
    cnt_inc = (c == 5'h1f) ? c : c + 5'h01;
  endfunction : cnt_inc

  always_comb begin
    st_nxt = st_r;
    bit_cnt_nxt = bit_cnt_r;
    sh_nxt = sh_r;
    byte_idx_nxt = byte_idx_r;
    crc_mode_nxt = crc_mode_r;
    rd_mode_nxt = rd_mode_r;
    base_nxt = base_r;
    ptr_nxt = ptr_r;
    len_nxt = len_r;
    hdr_ok_nxt = hdr_ok_r;
    crc4_nxt = crc4_r;
    crc8_nxt = crc8_r;
    tx_word_nxt = tx_word_r;
    hi_sel_nxt = hi_sel_r;
    tx_sh_nxt = tx_sh_r;
    data_cnt_nxt = data_cnt_r;
    ack_drv_nxt = ack_drv_r;
    oe_b_nxt = oe_b_r;
    hold_nxt = hold_r;
    commit_left_nxt = commit_left_r;
    commit_base_nxt = commit_base_r;
    frame_open_nxt = frame_open_r;
    rd_fetch_nxt = 1'b0;
    rd_addr_nxt = rd_addr_r;
    crc_err_nxt = 1'b0;
    crc8_bad = 1'b0;
    data_byte = 1'b0;
    rx_byte = {sh_r[6:0], sda_s2_r};
    // one held word leaves per cycle, long before the next byte lands
    if (wr_en) begin
      commit_left_nxt = commit_left_r - 2'd1;
      commit_base_nxt = commit_base_r + 8'h02;
      hold_nxt = {16'h0000, hold_r[31:16]};
    end
    if (start_det) begin
      st_nxt = ST_RX;
      bit_cnt_nxt = 4'h0;
      byte_idx_nxt = 4'h0;
      ack_drv_nxt = 1'b0;
      oe_b_nxt = 1'b1;
      frame_open_nxt = 1'b1;
      // repeated start keeps the running crc of the whole frame
      if (!frame_open_r) begin
        crc4_nxt = CRC4_INIT;
        crc8_nxt = CRC8_INIT;
      end
    end else if (stop_det) begin
      st_nxt = ST_IDLE;
      oe_b_nxt = 1'b1;
      ack_drv_nxt = 1'b0;
      frame_open_nxt = 1'b0;
    end else begin
      case (st_r)
        ST_RX: begin
          if (scl_rise && bit_cnt_r != BIT_ACK) begin
            sh_nxt = rx_byte;
            bit_cnt_nxt = bit_cnt_r + 4'h1;
            if (bit_cnt_r == BIT_LAST) begin
              ack_drv_nxt = 1'b1;
              crc8_nxt = crc8_byte(crc8_r, rx_byte);
              if (byte_idx_r != 4'hf) byte_idx_nxt = byte_idx_r + 4'h1;
              if (byte_idx_r == 4'h0) begin
                if (rx_byte[7:2] != SLAVE_BASE[6:1]) begin
                  st_nxt = ST_IGN;
                  ack_drv_nxt = 1'b0;
                end else begin
                  crc_mode_nxt = rx_byte[1];
                  rd_mode_nxt = rx_byte[0];
                  if (rx_byte[0]) begin
                    // read re-enters at the last memory address set
                    ptr_nxt = base_r;
                    tx_word_nxt = read_map(base_r);
                    tx_sh_nxt = tx_word_nxt[7:0];
                    hi_sel_nxt = 1'b1;
                    data_cnt_nxt = 5'h00;
                    rd_fetch_nxt = 1'b1;
                    rd_addr_nxt = base_r;
                  end else begin
                    crc4_nxt = crc4_bits(CRC4_INIT, rx_byte, BYTE);
                    hdr_ok_nxt = !rx_byte[1];
                  end
                end
              end else if (!rd_mode_r) begin
                if (byte_idx_r == 4'h1) begin
                  base_nxt = rx_byte;
                  ptr_nxt = rx_byte;
                  data_cnt_nxt = 5'h00;
                  crc4_nxt = crc4_bits(crc4_r, rx_byte, BYTE);
                end else if (crc_mode_r && byte_idx_r == 4'h2) begin
                  len_nxt = rx_byte[7:4];
                  hdr_ok_nxt = crc4_bits(crc4_r, rx_byte, NIB) == rx_byte[3:0];
                  crc_err_nxt = !hdr_ok_nxt;
                end else if (!crc_mode_r) begin
                  data_byte = 1'b1;
                  hold_nxt[{data_cnt_r[0], 3'b000} +: 8] = rx_byte;
                  if (data_cnt_r[0]) begin
                    commit_left_nxt = 2'd1;
                    commit_base_nxt = ptr_r;
                    ptr_nxt = ptr_r + 8'h02;
                  end
                end else if (data_cnt_r <= {1'b0, len_r}) begin
                  data_byte = 1'b1;
                  if (data_cnt_r < 5'h04) begin
                    hold_nxt[{data_cnt_r[1:0], 3'b000} +: 8] = rx_byte;
                  end
                end else if (data_cnt_r == {1'b0, len_r} + 5'h01) begin
                  data_byte = 1'b1;
                  crc8_bad = rx_byte != crc8_r;
                  crc_err_nxt = crc8_bad;
                  // only whole words with both checks good reach the registers
                  if (!crc8_bad && hdr_ok_r && len_r[0] && len_r <= CRC_LEN_MAX) begin
                    commit_left_nxt = {1'b0, len_r[1]} + 2'd1;
                    commit_base_nxt = base_r;
                  end
                end
                if (data_byte) data_cnt_nxt = cnt_inc(data_cnt_r);
              end
            end
          end else if (scl_rise) begin
            bit_cnt_nxt = 4'h0;
            ack_drv_nxt = 1'b0;
            if (rd_mode_r) st_nxt = ST_TX;
          end else if (scl_fall) begin
            oe_b_nxt = !ack_drv_r;
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            oe_b_nxt = (bit_cnt_r == BIT_ACK) ? 1'b1 : tx_sh_r[3'd7 - bit_cnt_r[2:0]];
          end else if (scl_rise && bit_cnt_r != BIT_ACK) begin
            bit_cnt_nxt = bit_cnt_r + 4'h1;
            if (bit_cnt_r == BIT_LAST) crc8_nxt = crc8_byte(crc8_r, tx_sh_r);
          end else if (scl_rise) begin
            bit_cnt_nxt = 4'h0;
            if (sda_s2_r) begin
              st_nxt = ST_IGN;
            end else begin
              data_cnt_nxt = cnt_inc(data_cnt_r);
              if (crc_mode_r && data_cnt_r == {1'b0, len_r}) begin
                tx_sh_nxt = crc8_r;
              end else if (crc_mode_r && data_cnt_r > {1'b0, len_r}) begin
                tx_sh_nxt = TX_FILL;
              end else if (hi_sel_r) begin
                tx_sh_nxt = tx_word_r[15:8];
                hi_sel_nxt = 1'b0;
              end else begin
                ptr_nxt = ptr_r + 8'h02;
                tx_word_nxt = read_map(ptr_nxt);
                tx_sh_nxt = tx_word_nxt[7:0];
                hi_sel_nxt = 1'b1;
                rd_fetch_nxt = 1'b1;
                rd_addr_nxt = ptr_nxt;
              end
            end
          end
        end
        ST_IDLE, ST_IGN: begin
          oe_b_nxt = 1'b1;
        end
        default: begin
          st_nxt = ST_IDLE;
          oe_b_nxt = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      sh_r <= 8'h00;
      byte_idx_r <= 4'h0;
      crc_mode_r <= 1'b0;
      rd_mode_r <= 1'b0;
      base_r <= 8'h00;
      ptr_r <= 8'h00;
      len_r <= 4'h0;
      hdr_ok_r <= 1'b0;
      crc4_r <= CRC4_INIT;
      crc8_r <= CRC8_INIT;
      tx_word_r <= 16'h0000;
      hi_sel_r <= 1'b0;
      tx_sh_r <= 8'h00;
      data_cnt_r <= 5'h00;
      ack_drv_r <= 1'b0;
      oe_b_r <= 1'b1;
      hold_r <= 32'h0000_0000;
      commit_left_r <= 2'd0;
      commit_base_r <= 8'h00;
      frame_open_r <= 1'b0;
      rd_fetch_r <= 1'b0;
      rd_addr_r <= 8'h00;
      crc_err_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      sh_r <= sh_nxt;
      byte_idx_r <= byte_idx_nxt;
      crc_mode_r <= crc_mode_nxt;
      rd_mode_r <= rd_mode_nxt;
      base_r <= base_nxt;
      ptr_r <= ptr_nxt;
      len_r <= len_nxt;
      hdr_ok_r <= hdr_ok_nxt;
      crc4_r <= crc4_nxt;
      crc8_r <= crc8_nxt;
      tx_word_r <= tx_word_nxt;
      hi_sel_r <= hi_sel_nxt;
      tx_sh_r <= tx_sh_nxt;
      data_cnt_r <= data_cnt_nxt;
      ack_drv_r <= ack_drv_nxt;
      oe_b_r <= oe_b_nxt;
      hold_r <= hold_nxt;
      commit_left_r <= commit_left_nxt;
      commit_base_r <= commit_base_nxt;
      frame_open_r <= frame_open_nxt;
      rd_fetch_r <= rd_fetch_nxt;
      rd_addr_r <= rd_addr_nxt;
      crc_err_r <= crc_err_nxt;
    end
  end

  always_comb begin
    set_v = 16'h0000;
    clr_v = 16'h0000;
    temp_nxt = temp_r;
    press_nxt = press_r;
    sync_up_nxt = sync_up_r;
    sleep_nxt = sleep_r;
    reload_nxt = 1'b0;
    if (temp_load) begin
      temp_nxt = temp_value;
      set_v[B_T_UP] = 1'b1;
      set_v[B_T_MISS] = status_r[B_T_UP];
    end
    if (press_load) begin
      press_nxt = press_value;
      set_v[B_S_UP] = 1'b1;
      set_v[B_S_MISS] = status_r[B_S_UP];
    end
    set_v[B_BS] = bs_fail_ev;
    set_v[B_BC] = bc_fail_ev;
    set_v[B_CRC] = crc_err_r;
    if (rd_fetch_r && rd_addr_r == ADDR_TEMP) begin
      clr_v[B_T_UP] = 1'b1;
      sync_up_nxt[1] = status_r[B_T_UP];
    end
    if (rd_fetch_r && rd_addr_r == ADDR_PRESS) begin
      clr_v[B_S_UP] = 1'b1;
      sync_up_nxt[0] = status_r[B_S_UP];
    end
    // any other address but ADDR_STAT and ADDR_CMD simply falls through unchanged
    if (wr_en && commit_base_r == ADDR_STAT) begin
      clr_v = clr_v | (hold_r[15:0] & EVENT_MASK);
    end
    // set beats clear so an event landing on a clear is kept
    status_nxt = ((status_r & ~clr_v) | set_v) & EVENT_MASK;
    if (wake_pulse) sleep_nxt = 1'b0;
    if (wr_en && commit_base_r == ADDR_CMD) begin
      if (hold_r[15:0] == CMD_SLEEP) sleep_nxt = 1'b1;
      if (hold_r[15:0] == CMD_RESET) begin
        reload_nxt = 1'b1;
        status_nxt = STATUS_RST;
        sync_up_nxt = 2'b00;
        temp_nxt = RESULT_RST;
        press_nxt = RESULT_RST;
        sleep_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      status_r <= STATUS_RST;
      temp_r <= RESULT_RST;
      press_r <= RESULT_RST;
      sync_up_r <= 2'b00;
      sleep_r <= 1'b0;
      reload_r <= 1'b0;
      sda_o_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      temp_r <= temp_nxt;
      press_r <= press_nxt;
      sync_up_r <= sync_up_nxt;
      sleep_r <= sleep_nxt;
      reload_r <= reload_nxt;
      sda_o_r <= 1'b0;
    end
  end

  assign sda_o = sda_o_r;
  assign sda_oe_b = oe_b_r;
  assign sleep_mode = sleep_r;
  assign reload_req = reload_r;
  assign temp_result = temp_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_reload_pulse;
    reload_req ##1 !reload_req;
  endsequence

  a_cmd_sleep: assert property (wr_en && commit_base_r == ADDR_CMD && hold_r[15:0] == CMD_SLEEP
    && !wake_pulse |=> sleep_mode) else $error("sleep command not taken");
  a_cmd_reset: assert property (wr_en && commit_base_r == ADDR_CMD && hold_r[15:0] == CMD_RESET
    |=> s_reload_pulse and status_r == STATUS_RST) else $error("reset command failed");
  a_temp_guard: assert property (wr_en && commit_base_r == ADDR_TEMP && !temp_load
    |=> temp_r == $past(temp_r)) else $error("protected register written");
  a_event_clear: assert property (wr_en && commit_base_r == ADDR_STAT && hold_r[B_CRC]
    && !crc_err_r |=> !status_r[B_CRC]) else $error("event not cleared");
  a_temp_event: assert property (temp_load && !reload_nxt
    |=> status_r[B_T_UP] && temp_r == $past(temp_value))
    else $error("temperature event missing");
  a_wake_clear: assert property (wake_pulse
    && !(wr_en && commit_base_r == ADDR_CMD && hold_r[15:0] == CMD_SLEEP)
    |=> !sleep_mode) else $error("wake did not clear sleep");
  a_crc_flag: assert property (crc_err_r |=> status_r[B_CRC])
    else $error("crc error not flagged");
  a_crc_drop: assert property (crc8_bad |=> commit_left_r == 2'd0 [*2])
    else $error("bad crc frame committed");
  a_crc_tail: assert property (st_r == ST_TX && scl_rise && bit_cnt_r == BIT_ACK && !sda_s2_r
    && crc_mode_r && data_cnt_r == {1'b0, len_r} && !start_det && !stop_det
    |=> tx_sh_r == $past(crc8_r)) else $error("crc8 byte not appended");
  a_read_walk: assert property (rd_fetch_r && st_r == ST_TX
    |-> ptr_r == rd_addr_r && $past(ptr_r) + 8'h02 == ptr_r) else $error("read skipped");
endmodule : sensor_port

// File: host_model.sv
// i2c master model standing on the far side of the sensor port
`timescale 1ns/10ps
module host_model (
  output logic scl,
  output logic sda_pull,
  input wire logic sda_in
);
  localparam real Q = 31.25;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // doubles as repeated start; long low phase lets the device drop its ack first
  task automatic start();
    sda_pull = 1'b0;
    #(2*Q) scl = 1'b1;
    #(2*Q) sda_pull = 1'b1;
    #(2*Q) scl = 1'b0;
  endtask : start
  task automatic stop();
    #Q sda_pull = 1'b1;
    #Q scl = 1'b1;
    #(2*Q) sda_pull = 1'b0;
    #(2*Q);
  endtask : stop
  // sda moves only in the low phase; scl then stands high between frames
  task automatic bit_io(input logic b, output logic r);
    #Q sda_pull = ~b;
    #Q scl = 1'b1;
    #Q r = sda_in;
    #Q scl = 1'b0;
  endtask : bit_io
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : wr_byte
  // last byte of a read is refused so the device lets go of sda
  task automatic rd_byte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(last, r);
  endtask : rd_byte
endmodule : host_model

// File: sensor_register_port_with_crc_tb_top.sv
// self-checking bench for the sensor register port
`timescale 1ns/10ps
module sensor_register_port_with_crc_tb_top import sensor_port_pkg::*;;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic scl, sda_pull, sda_o, sda_oe_b, sleep_mode, reload_req;
  logic [15:0] temp_value = 16'h0000;
  logic [15:0] press_value = 16'h0000;
  logic [15:0] temp_result;
  logic temp_load = 1'b0, press_load = 1'b0, idle_in = 1'b1, dsp_sat_in = 1'b0;
  logic bs_fail_ev = 1'b0, bc_fail_ev = 1'b0;
  int num_errors = 0;
  int n_checks = 0;
  int n_reload = 0;
  // open-drain wire with pull-up
  wire logic sda = ~(sda_pull | (~sda_oe_b & ~sda_o));
  always #2.5 clk = ~clk;
  always @(posedge clk) if (reload_req === 1'b1) n_reload <= n_reload + 1;

  sensor_port sensor_port_inst (.clk(clk), .rst_b(rst_b), .scl(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_b(sda_oe_b), .temp_value(temp_value), .temp_load(temp_load),
    .press_value(press_value), .press_load(press_load), .idle_in(idle_in),
    .dsp_sat_in(dsp_sat_in), .bs_fail_ev(bs_fail_ev), .bc_fail_ev(bc_fail_ev),
    .sleep_mode(sleep_mode), .reload_req(reload_req), .temp_result(temp_result));
  host_model host_model_inst (.scl(scl), .sda_pull(sda_pull), .sda_in(sda));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [7:0] c8(input logic [7:0] q[$]);
    logic [7:0] c = CRC8_INIT;
    foreach (q[k])
      for (int i = 7; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ q[k][i]) ? CRC8_POLY : 8'h00);
    return c;
  endfunction : c8
  // length nibble plus crc4 over slave byte, memory address and length
  function automatic logic [7:0] lc(input logic [7:0] a, input logic [7:0] m);
    logic [19:0] d = {a, m, 4'h1};
    logic [3:0] c = CRC4_INIT;
    for (int i = 19; i >= 0; i--) c = {c[2:0], 1'b0} ^ ((c[3] ^ d[i]) ? CRC4_POLY : 4'h0);
    return {4'h1, c};
  endfunction : lc
  // offset keeps wire changes clear of the core clock edges
  task automatic wframe(input logic [7:0] q[$]);
    logic a;
    #1.1;
    host_model_inst.start();
    foreach (q[i]) begin
      host_model_inst.wr_byte(q[i], a);
      chk({15'h0000, a}, 16'h0001);
    end
    host_model_inst.stop();
  endtask : wframe
  task automatic rframe(input logic [7:0] q[$], input int n, output logic [7:0] d[$]);
    logic a;
    logic [7:0] b;
    d = {};
    #1.1;
    host_model_inst.start();
    foreach (q[i]) host_model_inst.wr_byte(q[i], a);
    host_model_inst.start();
    host_model_inst.wr_byte(q[0] | 8'h01, a);
    for (int i = 0; i < n; i++) begin
      host_model_inst.rd_byte(i == n - 1, b);
      d.push_back(b);
    end
    host_model_inst.stop();
  endtask : rframe
  task automatic t_read_walk();
    logic [7:0] d[$];
    @(posedge clk);
    temp_value <= 16'h7df2;
    temp_load <= 1'b1;
    press_value <= 16'h82ea;
    @(posedge clk);
    temp_load <= 1'b0;
    press_load <= 1'b1;
    @(posedge clk);
    press_load <= 1'b0;
    chk(temp_result, 16'h7df2);
    rframe({8'hd8, ADDR_TEMP}, 6, d);
    chk({d[1], d[0]}, 16'h7df2);
    chk({d[3], d[2]}, 16'h82ea);
    chk({d[5], d[4]}, 16'h0019);
    $display("done read_walk");
  endtask : t_read_walk
  task automatic t_protect();
    wframe({8'hd8, ADDR_TEMP, 8'h34, 8'h12});
    @(posedge clk);
    chk(temp_result, 16'h7df2);
    $display("done protect");
  endtask : t_protect
  task automatic t_crc_clear();
    logic [7:0] d[$];
    logic [7:0] f[$];
    @(posedge clk);
    bs_fail_ev <= 1'b1;
    bc_fail_ev <= 1'b1;
    @(posedge clk);
    bs_fail_ev <= 1'b0;
    bc_fail_ev <= 1'b0;
    f = {8'hda, ADDR_STAT, lc(8'hda, ADDR_STAT), 8'h80, 8'h00};
    f.push_back(c8(f));
    wframe(f);
    rframe({8'hd8, ADDR_STAT}, 2, d);
    chk({d[1], d[0]}, 16'h0101);
    wframe({8'hd8, ADDR_STAT, 8'hff, 8'hff});
    rframe({8'hd8, ADDR_STAT}, 2, d);
    chk({d[1], d[0]}, 16'h0001);
    $display("done crc_clear");
  endtask : t_crc_clear
  task automatic t_crc_bad();
    logic [7:0] d[$];
    logic [7:0] f[$];
    @(posedge clk);
    bc_fail_ev <= 1'b1;
    dsp_sat_in <= 1'b1;
    @(posedge clk);
    bc_fail_ev <= 1'b0;
    f = {8'hda, ADDR_STAT, lc(8'hda, ADDR_STAT), 8'hff, 8'hff};
    f.push_back(~c8(f));
    wframe(f);
    f = {8'hda, ADDR_STAT, lc(8'hda, ADDR_STAT)};
    rframe(f, 3, d);
    chk({d[1], d[0]}, 16'h0d01);
    f = {f, 8'hdb, d[0], d[1]};
    chk({8'h00, d[2]}, {8'h00, c8(f)});
    $display("done crc_bad");
  endtask : t_crc_bad
  task automatic t_cmd();
    logic [7:0] d[$];
    wframe({8'hd8, ADDR_CMD, 8'h32, 8'h6c});
    chk({15'h0000, sleep_mode}, 16'h0001);
    // any later scl activity wakes the port again
    rframe({8'hd8, ADDR_TEMP}, 2, d);
    chk({15'h0000, sleep_mode}, 16'h0000);
    wframe({8'hd8, ADDR_CMD, 8'h69, 8'hb1});
    @(posedge clk);
    chk(n_reload[15:0], 16'h0001);
    chk(temp_result, RESULT_RST);
    chk({15'h0000, sleep_mode}, 16'h0000);
    $display("done cmd");
  endtask : t_cmd
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  // the port's scl and sda sync flops take their idle value on the first reset edge
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    chk(temp_result, RESULT_RST);
    chk({14'h0000, sleep_mode, reload_req}, 16'h0000);
    t_read_walk();
    t_protect();
    t_crc_clear();
    t_crc_bad();
    t_cmd();
    give_verdict();
  end
  // about 60 bytes at 1.1 us each, with ample margin
  initial begin
    #200000;
    num_errors++;
    $display("watchdog expired");
    give_verdict();
  end
endmodule : sensor_register_port_with_crc_tb_top
